// ===== logic/cfg_status_regs.svh
// register offsets, field positions, widths and response codes of the configuration status mirror
`ifndef CFG_STATUS_REGS_SVH
`define CFG_STATUS_REGS_SVH
`define OFS_MODE 8'h00
`define OFS_PF_LINK 8'h04
`define OFS_PF_DPA 8'h08
`define OFS_DEV_CTL2 8'h0C
`define OFS_RP_LINK_CTL 8'h10
`define OFS_LINK_STATUS 8'h14
`define OFS_EVENT_IN 8'h18
`define OFS_PF_TPH 8'h1C
`define OFS_VF_TPH_EN 8'h20
`define OFS_VF_ST_MODE 8'h24
`define BIT_ROOT_PORT 0
`define BIT_PF0_RCB 0
`define BIT_PF1_RCB 1
`define BIT_RP_RCB 0
`define BIT_BW_MGMT_IE 1
`define BIT_AUTO_BW_IE 2
`define BIT_EQ_IE 3
`define BIT_BW_MGMT_ST 0
`define BIT_AUTO_BW_ST 1
`define BIT_EQ_REQ_ST 2
`define BIT_TPH_REQ_EN 8
`define NUM_PF 2
`define NUM_VF 6
`define ST_MODE_W 3
`define DPA_STATE_W 5
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== logic/cfg_status_pkg.sv
// types shared by the configuration status mirror
package cfg_status_pkg;
  typedef struct packed {
    logic [1:0] rcb;
    logic [1:0] dpa_change;
    logic [1:0] obff;
    logic link_event;
    logic [1:0] pf_hint_en;
    logic [5:0] pf_st_modes;
    logic [5:0] vf_hint_en;
    logic [17:0] vf_st_modes;
  } status_out_type;
  typedef struct packed {
    logic bw_mgmt;
    logic auto_bw;
    logic eq_req;
  } link_event_type;
endpackage

// ===== logic/event_sync.sv
// two-flop synchroniser with rising edge detector for link events
`timescale 1ns/1ns
`default_nettype none
module event_sync
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [2:0] i_async,
  output logic [2:0] o_rise
);
  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
    logic [2:0] last;
  } sync_state_type;
  sync_state_type state_r;
  sync_state_type state_nxt;
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.meta = i_async;
    state_nxt.sync = state_r.meta;
    state_nxt.last = state_r.sync;
  end
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end
  assign o_rise = state_r.sync & ~state_r.last;
endmodule
`default_nettype wire

// ===== logic/cfg_status_outputs.sv
// configuration status mirror with an AXI4-Lite register slave
// ==========================================================
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "cfg_status_regs.svh"
module cfg_status_outputs
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_bw_mgmt_event,
  input wire logic i_auto_bw_event,
  input wire logic i_eq_request,
  output logic [1:0] o_rcb_status,
  output logic [1:0] o_dpa_substate_change,
  output logic [1:0] o_obff_enable,
  output logic o_link_event_interrupt,
  output logic [1:0] o_tph_requester_enable,
  output logic [5:0] o_pf_steering_tag_modes,
  output logic [5:0] o_vf_hint_requester_enables,
  output logic [17:0] o_vf_steering_tag_modes
);
  // ==========================================================
  // state
  typedef struct packed {
    logic root_port;
    logic [1:0] pf_link;
    logic [9:0] pf_dpa;
    logic [1:0] obff;
    logic [3:0] rp_link_ctl;
    logic [2:0] link_status;
    logic [31:0] pf_tph;
    logic [5:0] vf_tph_en;
    logic [17:0] vf_st;
    logic [1:0] dpa_pulse;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    cfg_status_pkg::status_out_type outs;
  } state_type;
  state_type state_r;
  state_type state_nxt;
  logic [2:0] ev_rise;
  cfg_status_pkg::link_event_type ev;
  event_sync u_event_sync
  (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_async({i_eq_request, i_auto_bw_event, i_bw_mgmt_event}),
    .o_rise(ev_rise)
  );
  // map by name: the first struct member is the msb, the sync bus has the bandwidth management event at bit 0
  assign ev = '{bw_mgmt: ev_rise[0], auto_bw: ev_rise[1], eq_req: ev_rise[2]};
  // ==========================================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = nw[i*8 +: 8];
    end
    return res;
  endfunction
  function automatic logic mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      `OFS_MODE, `OFS_PF_LINK, `OFS_PF_DPA, `OFS_DEV_CTL2, `OFS_RP_LINK_CTL,
      `OFS_LINK_STATUS, `OFS_EVENT_IN, `OFS_PF_TPH, `OFS_VF_TPH_EN, `OFS_VF_ST_MODE:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
    return hit;
  endfunction
  // ==========================================================
  // next state
  always_comb
  begin
    logic [31:0] wv;
    logic do_write;
    logic [2:0] set_st;
    logic [2:0] clr_st;
    wv = '0;
    do_write = 1'b0;
    set_st = '0;
    clr_st = '0;
    state_nxt = state_r;
    state_nxt.dpa_pulse = 2'h0;
    if (i_awvalid && o_awready)
    begin
      state_nxt.aw_held = 1'b1;
      state_nxt.aw_addr = {i_awaddr[7:2], 2'h0};
    end
    if (i_wvalid && o_wready)
    begin
      state_nxt.w_held = 1'b1;
      state_nxt.w_data = i_wdata;
      state_nxt.w_strb = i_wstrb;
    end
    if (state_r.aw_held && state_r.w_held && !state_r.bvalid)
    begin
      do_write = 1'b1;
      state_nxt.aw_held = 1'b0;
      state_nxt.w_held = 1'b0;
      state_nxt.bvalid = 1'b1;
      state_nxt.bresp = mapped(state_r.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (state_r.bvalid && i_bready)
      state_nxt.bvalid = 1'b0;
    if (do_write)
    begin
      case (state_r.aw_addr)
        `OFS_MODE:
        begin
          wv = merge({31'h0, state_r.root_port}, state_r.w_data, state_r.w_strb);
          state_nxt.root_port = wv[`BIT_ROOT_PORT];
        end
        `OFS_PF_LINK:
        begin
          wv = merge({30'h0, state_r.pf_link}, state_r.w_data, state_r.w_strb);
          state_nxt.pf_link = wv[1:0];
        end
        `OFS_PF_DPA:
        begin
          wv = merge({22'h0, state_r.pf_dpa}, state_r.w_data, state_r.w_strb);
          state_nxt.pf_dpa = wv[9:0];
          for (int f = 0; f < `NUM_PF; f++)
          begin
            if (wv[f*`DPA_STATE_W +: `DPA_STATE_W] != state_r.pf_dpa[f*`DPA_STATE_W +: `DPA_STATE_W]
                && !state_r.root_port)
              state_nxt.dpa_pulse[f] = 1'b1;
          end
        end
        `OFS_DEV_CTL2:
        begin
          wv = merge({30'h0, state_r.obff}, state_r.w_data, state_r.w_strb);
          state_nxt.obff = wv[1:0];
        end
        `OFS_RP_LINK_CTL:
        begin
          wv = merge({28'h0, state_r.rp_link_ctl}, state_r.w_data, state_r.w_strb);
          state_nxt.rp_link_ctl = wv[3:0];
        end
        `OFS_LINK_STATUS:
          if (state_r.w_strb[0])
            clr_st = state_r.w_data[2:0];
        `OFS_PF_TPH:
          state_nxt.pf_tph = merge(state_r.pf_tph, state_r.w_data, state_r.w_strb);
        `OFS_VF_TPH_EN:
        begin
          wv = merge({26'h0, state_r.vf_tph_en}, state_r.w_data, state_r.w_strb);
          state_nxt.vf_tph_en = wv[5:0];
        end
        `OFS_VF_ST_MODE:
        begin
          wv = merge({14'h0, state_r.vf_st}, state_r.w_data, state_r.w_strb);
          state_nxt.vf_st = wv[17:0];
        end
        default:
          wv = '0;
      endcase
    end
    // link events only matter for a root port; set wins over a write-one clear
    if (state_r.root_port)
      set_st = {ev.eq_req, ev.auto_bw, ev.bw_mgmt};
    state_nxt.link_status = (state_r.link_status & ~clr_st) | set_st;
    if (i_arvalid && o_arready)
    begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rresp = mapped({i_araddr[7:2], 2'h0}) ? `RESP_OKAY : `RESP_SLVERR;
      case ({i_araddr[7:2], 2'h0})
        `OFS_MODE: state_nxt.rdata = {31'h0, state_r.root_port};
        `OFS_PF_LINK: state_nxt.rdata = {30'h0, state_r.pf_link};
        `OFS_PF_DPA: state_nxt.rdata = {22'h0, state_r.pf_dpa};
        `OFS_DEV_CTL2: state_nxt.rdata = {30'h0, state_r.obff};
        `OFS_RP_LINK_CTL: state_nxt.rdata = {28'h0, state_r.rp_link_ctl};
        `OFS_LINK_STATUS: state_nxt.rdata = {29'h0, state_r.link_status};
        `OFS_EVENT_IN: state_nxt.rdata = {29'h0, ev_rise};
        `OFS_PF_TPH: state_nxt.rdata = state_r.pf_tph;
        `OFS_VF_TPH_EN: state_nxt.rdata = {26'h0, state_r.vf_tph_en};
        `OFS_VF_ST_MODE: state_nxt.rdata = {14'h0, state_r.vf_st};
        default: state_nxt.rdata = 32'h0;
      endcase
    end
    else if (state_r.rvalid && i_rready)
      state_nxt.rvalid = 1'b0;
    // outputs registered from the current copy: one cycle behind a write
    if (state_r.root_port)
      state_nxt.outs.rcb = {1'b0, state_r.rp_link_ctl[`BIT_RP_RCB]};
    else
      state_nxt.outs.rcb = {state_r.pf_link[`BIT_PF1_RCB], state_r.pf_link[`BIT_PF0_RCB]};
    state_nxt.outs.dpa_change = state_r.root_port ? 2'h0 : state_r.dpa_pulse;
    state_nxt.outs.obff = state_r.obff;
    state_nxt.outs.link_event = state_r.root_port &&
      ((state_r.link_status[`BIT_BW_MGMT_ST] && state_r.rp_link_ctl[`BIT_BW_MGMT_IE]) ||
       (state_r.link_status[`BIT_AUTO_BW_ST] && state_r.rp_link_ctl[`BIT_AUTO_BW_IE]) ||
       (state_r.link_status[`BIT_EQ_REQ_ST] && state_r.rp_link_ctl[`BIT_EQ_IE]));
    for (int f = 0; f < `NUM_PF; f++)
    begin
      state_nxt.outs.pf_hint_en[f] = state_r.pf_tph[f*16 + `BIT_TPH_REQ_EN];
      state_nxt.outs.pf_st_modes[f*`ST_MODE_W +: `ST_MODE_W] = state_r.pf_tph[f*16 +: `ST_MODE_W];
    end
    state_nxt.outs.vf_hint_en = state_r.vf_tph_en;
    state_nxt.outs.vf_st_modes = state_r.vf_st;
  end
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end
  // ==========================================================
  // ports
  assign o_awready = !state_r.aw_held;
  assign o_wready = !state_r.w_held;
  assign o_bvalid = state_r.bvalid;
  assign o_bresp = state_r.bresp;
  assign o_arready = !state_r.rvalid;
  assign o_rvalid = state_r.rvalid;
  assign o_rdata = state_r.rdata;
  assign o_rresp = state_r.rresp;
  assign o_rcb_status = state_r.outs.rcb;
  assign o_dpa_substate_change = state_r.outs.dpa_change;
  assign o_obff_enable = state_r.outs.obff;
  assign o_link_event_interrupt = state_r.outs.link_event;
  assign o_tph_requester_enable = state_r.outs.pf_hint_en;
  assign o_pf_steering_tag_modes = state_r.outs.pf_st_modes;
  assign o_vf_hint_requester_enables = state_r.outs.vf_hint_en;
  assign o_vf_steering_tag_modes = state_r.outs.vf_st_modes;
endmodule
`default_nettype wire

// ===== sim/cfg_status_outputs_chk.sv
// concurrent checks on the configuration status mirror ports
`timescale 1ns/1ns
`default_nettype none
module cfg_status_outputs_chk
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_bready,
  input wire logic i_rready,
  input wire logic o_bvalid,
  input wire logic [1:0] o_bresp,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rcb_status,
  input wire logic [1:0] o_dpa_substate_change,
  input wire logic [1:0] o_obff_enable,
  input wire logic o_link_event_interrupt,
  input wire logic [1:0] o_tph_requester_enable,
  input wire logic [5:0] o_pf_steering_tag_modes,
  input wire logic [5:0] o_vf_hint_requester_enables,
  input wire logic [17:0] o_vf_steering_tag_modes
);
  logic [3:0] bv_hist_r;
  logic wr_recent;
  // mirrors may only move in the few cycles after a write response
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      bv_hist_r <= 4'h0;
    else
      bv_hist_r <= {bv_hist_r[2:0], o_bvalid};
  end
  assign wr_recent = |bv_hist_r;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  // ==========================================
  // properties
  sequence s_dpa_quiet;
    (o_dpa_substate_change == 2'h0) [*2];
  endsequence
  a_dpa_one_cycle: assert property ((|o_dpa_substate_change) |=> s_dpa_quiet)
    else $error("power change pulse longer than one cycle");
  a_dpa_by_write: assert property ((|o_dpa_substate_change) |-> wr_recent)
    else $error("power change pulse without a write");
  a_mode_exclusive: assert property (!(o_link_event_interrupt && (|o_dpa_substate_change)))
    else $error("link event and power change together");
  a_obff_by_write: assert property ($changed(o_obff_enable) |-> wr_recent)
    else $error("obff output moved without a write");
  a_rcb_by_write: assert property ($changed(o_rcb_status) |-> wr_recent)
    else $error("boundary output moved without a write");
  a_tph_by_write: assert property ($changed({o_tph_requester_enable, o_pf_steering_tag_modes,
    o_vf_hint_requester_enables, o_vf_steering_tag_modes}) |-> wr_recent)
    else $error("hint outputs moved without a write");
  a_bresp_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
endmodule
bind cfg_status_outputs cfg_status_outputs_chk u_chk (.i_clk, .i_nrst, .i_bready, .i_rready, .o_bvalid,
  .o_bresp, .o_rvalid, .o_rdata, .o_rcb_status, .o_dpa_substate_change, .o_obff_enable,
  .o_link_event_interrupt, .o_tph_requester_enable, .o_pf_steering_tag_modes,
  .o_vf_hint_requester_enables, .o_vf_steering_tag_modes);
`default_nettype wire

// ===== sim/status_sink.sv
// user-side consumer counting power allocation change pulses
`timescale 1ns/1ns
`default_nettype none
module status_sink
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [1:0] i_dpa_change,
  output logic [7:0] o_cnt0,
  output logic [7:0] o_cnt1
);
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_cnt0 <= 8'h00;
      o_cnt1 <= 8'h00;
    end
    else
    begin
      o_cnt0 <= o_cnt0 + {7'h00, i_dpa_change[0]};
      o_cnt1 <= o_cnt1 + {7'h00, i_dpa_change[1]};
    end
  end
endmodule
`default_nettype wire

// ===== sim/cfg_status_outputs_bench.sv
// self-checking bench for the configuration status mirror
`timescale 1ns/1ns
`default_nettype none
`include "cfg_status_regs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module cfg_status_outputs_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [2:0] ev = 3'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [7:0] c0, c1;
  wire cfg_status_pkg::status_out_type so;
  int miscompares = 0;
  int checked = 0;
  cfg_status_outputs u_cfg_status_outputs (.i_clk(clk), .i_nrst(nrst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_bw_mgmt_event(ev[0]), .i_auto_bw_event(ev[1]), .i_eq_request(ev[2]),
    .o_rcb_status(so.rcb), .o_dpa_substate_change(so.dpa_change), .o_obff_enable(so.obff),
    .o_link_event_interrupt(so.link_event), .o_tph_requester_enable(so.pf_hint_en),
    .o_pf_steering_tag_modes(so.pf_st_modes), .o_vf_hint_requester_enables(so.vf_hint_en),
    .o_vf_steering_tag_modes(so.vf_st_modes));
  status_sink u_status_sink (.i_clk(clk), .i_nrst(nrst), .i_dpa_change(so.dpa_change), .o_cnt0(c0), .o_cnt1(c1));
  always #10 clk = ~clk;
  // ==========================================
  // bus tasks: response ready raised late so the hold is exercised
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bit done;
    done = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 40 && !done; n++)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid)
      begin
        done = 1;
        bready <= 1'b0;
        `CHK("bresp", er, bresp)
      end
      else if (bvalid) bready <= 1'b1;
    end
    `CHK("write done", 1'b1, done)
    @(posedge clk);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    bit done;
    done = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 40 && !done; n++)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid)
      begin
        done = 1;
        rready <= 1'b0;
        `CHK("rresp", er, rresp)
        `CHK("rdata", ed, rdata)
      end
      else if (rvalid) rready <= 1'b1;
    end
    `CHK("read done", 1'b1, done)
  endtask
  task automatic fire(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    repeat (4) @(posedge clk);
    ev[k] <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask
  // ==========================================
  // scenarios
  task automatic t_mirror;
    `CHK("outs after reset", 39'h0, so)
    wr(`OFS_PF_LINK, 32'h2, `RESP_OKAY);
    `CHK("rcb", 2'h2, so.rcb)
    for (int i = 0; i < 4; i++)
    begin
      wr(`OFS_DEV_CTL2, 32'(i), `RESP_OKAY);
      `CHK("obff", i[1:0], so.obff)
    end
    wr(`OFS_PF_TPH, 32'h0005_0103, `RESP_OKAY);
    `CHK("pf hint en", 2'h1, so.pf_hint_en)
    `CHK("pf st modes", 6'h2B, so.pf_st_modes)
    wr(`OFS_VF_TPH_EN, 32'h25, `RESP_OKAY);
    `CHK("vf hint en", 6'h25, so.vf_hint_en)
    wr(`OFS_VF_ST_MODE, 32'h2C688, `RESP_OKAY);
    `CHK("vf st modes", 18'h2C688, so.vf_st_modes)
    wr(8'h40, 32'h1, `RESP_SLVERR);
    rd_chk(8'h40, 32'h0, `RESP_SLVERR);
    rd_chk(`OFS_EVENT_IN, 32'h0, `RESP_OKAY);
    $display("t_mirror done");
  endtask
  task automatic t_dpa;
    wr(`OFS_PF_DPA, 32'hE0, `RESP_OKAY);
    wr(`OFS_PF_DPA, 32'hE0, `RESP_OKAY);
    wr(`OFS_PF_DPA, 32'hE1, `RESP_OKAY);
    `CHK("pulses f0", 8'h1, c0)
    `CHK("pulses f1", 8'h1, c1)
    $display("t_dpa done");
  endtask
  task automatic t_root;
    wr(`OFS_MODE, 32'h1, `RESP_OKAY);
    wr(`OFS_RP_LINK_CTL, 32'hF, `RESP_OKAY);
    `CHK("rp rcb", 2'h1, so.rcb)
    wr(`OFS_PF_DPA, 32'h0, `RESP_OKAY);
    `CHK("rp pulses", 16'h0101, {c1, c0})
    for (int k = 0; k < 3; k++)
    begin
      fire(k);
      `CHK("irq up", 1'b1, so.link_event)
      rd_chk(`OFS_LINK_STATUS, 32'(1 << k), `RESP_OKAY);
      wr(`OFS_LINK_STATUS, 32'(1 << k), `RESP_OKAY);
      `CHK("irq cleared", 1'b0, so.link_event)
    end
    wr(`OFS_RP_LINK_CTL, 32'h1, `RESP_OKAY);
    fire(1);
    `CHK("irq masked", 1'b0, so.link_event)
    rd_chk(`OFS_LINK_STATUS, 32'h2, `RESP_OKAY);
    // status left pending with all enables on: endpoint mode alone must keep the interrupt low
    wr(`OFS_MODE, 32'h0, `RESP_OKAY);
    wr(`OFS_RP_LINK_CTL, 32'hF, `RESP_OKAY);
    fire(0);
    `CHK("ep irq", 1'b0, so.link_event)
    rd_chk(`OFS_LINK_STATUS, 32'h2, `RESP_OKAY);
    $display("t_root done");
  endtask
  task report_and_stop;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    miscompares++;
    report_and_stop();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_mirror();
    t_dpa();
    t_root();
    report_and_stop();
  end
endmodule
`default_nettype wire
